// *** verilog/ciob_map.vh ***
// Constants for the character buffer channel: fields, widths, reset values
`ifndef CIOB_MAP_VH
`define CIOB_MAP_VH
`define CIOB_UNIT_HI 23
`define CIOB_UNIT_LO 18
`define CIOB_UA_MSB (23 - `CIOB_UNIT_LO)
`define CIOB_UA_LSB (23 - `CIOB_UNIT_HI)
`define CIOB_DIR_BIT 18
`define CIOB_CPW_HI 16
`define CIOB_CPW_LO 15
`define CIOB_CHAR_W 6
`define CIOB_WORD_W 24
`define CIOB_UNIT_NONE 6'h00
`define CIOB_WORD_ZERO 24'h000000
`define CIOB_LOW_HI 23
`define CIOB_LOW_LO 18
`define CIOB_TOP_HI 5
`define CIOB_TOP_LO 0
`endif

// *** verilog/ciob_skid.v ***
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module ciob_skid #(
    parameter WIDTH = 6
) (
    input wire clk,
    input wire rstn,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg [1:0] count;
    wire push;
    wire pop;

    assign inReady = (count != 2'd2);
    assign outValid = (count != 2'd0);
    assign outData = slot0;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // ========================================
    // Storage: slot0 is always the head entry
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
            count <= 2'd0;
        end else begin
            if (pop) begin
                slot0 <= slot1;
            end
            if (push) begin
                if (count == 2'd0 || (count == 2'd1 && pop)) begin
                    slot0 <= inData;
                end else begin
                    slot1 <= inData;
                end
            end
            if (push && !pop) begin
                count <= count + 2'd1;
            end else if (pop && !push) begin
                count <= count - 2'd1;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/ciob_channel.v ***
// Character-serial buffered channel: packs and unpacks 6-bit characters
`default_nettype none
`include "ciob_map.vh"
module ciob_channel #(
    parameter ADDR_W = 14,
    parameter WCNT_W = 14
) (
    input wire clk,
    input wire rstn,
    input wire ctlStrobe,
    input wire [23:0] ctlInstr,
    input wire ctlInterlace,
    input wire [WCNT_W-1:0] ctlWordCount,
    input wire [ADDR_W-1:0] ctlStartAddr,
    input wire toMemStrobe,
    input wire fromMemStrobe,
    input wire [23:0] fromMemWord,
    input wire terminateStrobe,
    input wire irqSystemEnable,
    output reg [23:0] cpuWord,
    output wire readyTestSkip,
    output wire errorTestSkip,
    output reg [5:0] panelUnit,
    output reg errorFlag,
    output reg wordFull,
    output reg wordIrq,
    output reg doneIrq,
    output reg doneProgramIrq,
    output reg memWrite,
    output reg memRead,
    output reg [ADDR_W-1:0] memAddr,
    output reg [23:0] memWriteData,
    input wire memReadValid,
    input wire [23:0] memReadData,
    output reg devStart,
    output reg [5:0] devUnit,
    input wire devCharValid,
    output wire devCharReady,
    input wire [5:0] devCharIn,
    input wire devParityIn,
    input wire devEndRecord,
    output wire devOutValid,
    input wire devOutReady,
    output wire [5:0] devCharOut,
    output wire devParityOut
);
    // ========================================
    // States
    localparam ST_IDLE = 3'd0;
    localparam ST_GET = 3'd1;
    localparam ST_WAIT = 3'd2;
    localparam ST_MEMRD = 3'd3;
    localparam ST_SEND = 3'd4;
    localparam ST_PAD = 3'd5;
    reg [2:0] state;
    reg [5:0] unitAddressReg;
    reg [1:0] charCountReg;
    reg [1:0] charCount;
    reg [23:0] wordAssemblyReg;
    reg [5:0] singleCharReg;
    reg [WCNT_W-1:0] wordCountReg;
    reg interlace;
    reg outputDir;
    reg endSeen;
    reg termSeen;
    reg pendValid;
    reg [5:0] pendChar;
    // Pins from the peripheral are asynchronous: two stages each
    reg [7:0] inSync1;
    reg [7:0] inSync2;
    reg [1:0] ctlSync1;
    reg [1:0] ctlSync2;
    wire syncValid;
    wire [5:0] syncChar;
    wire syncParity;
    wire syncEnd;
    wire syncOutReady;
    reg validSeen;
    function oddParity;
        input [5:0] ch;
        begin
            oddParity = ~(^ch);
        end
    endfunction
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            inSync1 <= 8'h00;
            inSync2 <= 8'h00;
            ctlSync1 <= 2'h0;
            ctlSync2 <= 2'h0;
        end else begin
            inSync1 <= {devParityIn, devCharValid, devCharIn};
            inSync2 <= inSync1;
            ctlSync1 <= {devEndRecord, devOutReady};
            ctlSync2 <= ctlSync1;
        end
    end
    assign syncChar = inSync2[5:0];
    assign syncValid = inSync2[6];
    assign syncParity = inSync2[7];
    assign syncEnd = ctlSync2[1];
    assign syncOutReady = ctlSync2[0];
    assign devCharReady = 1'b1;
    // ========================================
    // Output characters pass a two-entry buffer; a slow device stalls SEND
    wire skidReady;
    wire skidValid;
    wire [5:0] skidData;
    ciob_skid #(
        .WIDTH(`CIOB_CHAR_W)
    ) u_skid (
        .clk(clk),
        .rstn(rstn),
        .inValid(pendValid),
        .inReady(skidReady),
        .inData(pendChar),
        .outValid(skidValid),
        .outReady(syncOutReady),
        .outData(skidData)
    );
    assign devOutValid = skidValid;
    assign devCharOut = skidData;
    assign devParityOut = oddParity(skidData);
    assign readyTestSkip = (unitAddressReg == `CIOB_UNIT_NONE);
    assign errorTestSkip = errorFlag;
    wire newChar;
    wire lastChar;
    assign newChar = syncValid && !validSeen;
    assign lastChar = (charCount == 2'd0);
    // ========================================
    // Main sequencer
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            unitAddressReg <= `CIOB_UNIT_NONE;
            charCountReg <= 2'd0;
            charCount <= 2'd0;
            wordAssemblyReg <= `CIOB_WORD_ZERO;
            singleCharReg <= 6'h00;
            wordCountReg <= {WCNT_W{1'b0}};
            interlace <= 1'b0;
            outputDir <= 1'b0;
            endSeen <= 1'b0;
            termSeen <= 1'b0;
            pendValid <= 1'b0;
            pendChar <= 6'h00;
            validSeen <= 1'b0;
            cpuWord <= `CIOB_WORD_ZERO;
            panelUnit <= `CIOB_UNIT_NONE;
            errorFlag <= 1'b0;
            wordFull <= 1'b0;
            wordIrq <= 1'b0;
            doneIrq <= 1'b0;
            doneProgramIrq <= 1'b0;
            memWrite <= 1'b0;
            memRead <= 1'b0;
            memAddr <= {ADDR_W{1'b0}};
            memWriteData <= `CIOB_WORD_ZERO;
            devStart <= 1'b0;
            devUnit <= `CIOB_UNIT_NONE;
        end else begin
            wordIrq <= 1'b0;
            doneIrq <= 1'b0;
            doneProgramIrq <= 1'b0;
            memWrite <= 1'b0;
            memRead <= 1'b0;
            devStart <= 1'b0;
            validSeen <= syncValid;
            if (pendValid && skidReady) begin
                pendValid <= 1'b0;
            end
            if (terminateStrobe) begin
                termSeen <= 1'b1;
            end
            if (syncEnd && state != ST_IDLE) begin
                endSeen <= 1'b1;
            end
            if (ctlStrobe && state == ST_IDLE) begin
                unitAddressReg <= ctlInstr[`CIOB_UA_MSB:`CIOB_UA_LSB];
                panelUnit <= ctlInstr[`CIOB_UA_MSB:`CIOB_UA_LSB];
                outputDir <= ctlInstr[23 - `CIOB_DIR_BIT];
                // Bit 15 is the high-order bit; counts 1..4 held as n-1
                charCountReg <= {ctlInstr[23 - `CIOB_CPW_LO],
                    ctlInstr[23 - `CIOB_CPW_HI]};
                charCount <= {ctlInstr[23 - `CIOB_CPW_LO],
                    ctlInstr[23 - `CIOB_CPW_HI]};
                wordFull <= 1'b0;
                errorFlag <= 1'b0;
                devStart <= 1'b1;
                devUnit <= ctlInstr[`CIOB_UA_MSB:`CIOB_UA_LSB];
                interlace <= ctlInterlace;
                wordCountReg <= ctlWordCount;
                memAddr <= ctlStartAddr;
                endSeen <= 1'b0;
                termSeen <= 1'b0;
                wordAssemblyReg <= `CIOB_WORD_ZERO;
                if (ctlInstr[23 - `CIOB_DIR_BIT]) begin
                    if (ctlInterlace) begin
                        state <= ST_MEMRD;
                    end else begin
                        wordIrq <= 1'b1;
                        state <= ST_WAIT;
                    end
                end else begin
                    state <= ST_GET;
                end
            end else begin
                case (state)
                    ST_GET: begin
                        if (endSeen || syncEnd) begin
                            state <= ST_PAD;
                        end else if (newChar) begin
                            singleCharReg <= syncChar;
                            if (syncParity != oddParity(syncChar)) begin
                                errorFlag <= 1'b1;
                            end
                            if (lastChar) begin
                                wordAssemblyReg <= {wordAssemblyReg[17:0],
                                    syncChar};
                                wordFull <= 1'b1;
                                state <= ST_WAIT;
                                if (interlace) begin
                                    memWrite <= 1'b1;
                                    memWriteData <= {wordAssemblyReg[17:0],
                                        syncChar};
                                end else begin
                                    cpuWord <= {wordAssemblyReg[17:0],
                                        syncChar};
                                    wordIrq <= 1'b1;
                                end
                            end else begin
                                charCount <= charCount - 2'd1;
                                wordAssemblyReg <= {wordAssemblyReg[17:0],
                                    syncChar};
                            end
                        end
                    end
                    ST_PAD: begin
                        if (lastChar) begin
                            // Partial word ends the record; zeros fill it
                            wordFull <= 1'b1;
                            cpuWord <= {wordAssemblyReg[17:0], 6'h00};
                            unitAddressReg <= `CIOB_UNIT_NONE;
                            panelUnit <= `CIOB_UNIT_NONE;
                            doneIrq <= 1'b1;
                            doneProgramIrq <= irqSystemEnable;
                            if (interlace) begin
                                memWrite <= 1'b1;
                                memWriteData <= {wordAssemblyReg[17:0], 6'h00};
                            end
                            state <= ST_IDLE;
                        end else begin
                            charCount <= charCount - 2'd1;
                            wordAssemblyReg <= {wordAssemblyReg[17:0],
                                6'h00};
                        end
                    end
                    ST_WAIT: begin
                        if (!outputDir) begin
                            if (interlace || toMemStrobe) begin
                                charCount <= charCountReg;
                                wordAssemblyReg <= `CIOB_WORD_ZERO;
                                wordFull <= 1'b0;
                                if (interlace) begin
                                    memAddr <= memAddr + 1'b1;
                                    wordCountReg <= wordCountReg - 1'b1;
                                end
                                if (endSeen) begin
                                    unitAddressReg <= `CIOB_UNIT_NONE;
                                    panelUnit <= `CIOB_UNIT_NONE;
                                    doneIrq <= 1'b1;
                                    doneProgramIrq <= irqSystemEnable;
                                    state <= ST_IDLE;
                                end else begin
                                    if (interlace &&
                                        wordCountReg == {{(WCNT_W-1){1'b0}},
                                        1'b1}) begin
                                        interlace <= 1'b0;
                                    end
                                    state <= ST_GET;
                                end
                            end
                        end else if (termSeen) begin
                            unitAddressReg <= `CIOB_UNIT_NONE;
                            panelUnit <= `CIOB_UNIT_NONE;
                            doneIrq <= 1'b1;
                            doneProgramIrq <= irqSystemEnable;
                            state <= ST_IDLE;
                        end else if (fromMemStrobe) begin
                            wordAssemblyReg <= fromMemWord;
                            singleCharReg <= fromMemWord[23:18];
                            wordFull <= 1'b1;
                            charCount <= charCountReg;
                            state <= ST_SEND;
                        end
                    end
                    ST_MEMRD: begin
                        if (endSeen || wordCountReg == {WCNT_W{1'b0}}) begin
                            unitAddressReg <= `CIOB_UNIT_NONE;
                            panelUnit <= `CIOB_UNIT_NONE;
                            doneIrq <= 1'b1;
                            doneProgramIrq <= irqSystemEnable;
                            state <= ST_IDLE;
                        end else if (memReadValid) begin
                            wordAssemblyReg <= memReadData;
                            singleCharReg <= memReadData[23:18];
                            wordFull <= 1'b1;
                            charCount <= charCountReg;
                            memAddr <= memAddr + 1'b1;
                            wordCountReg <= wordCountReg - 1'b1;
                            state <= ST_SEND;
                        end else if (!memRead) begin
                            memRead <= 1'b1;
                        end
                    end
                    ST_SEND: begin
                        if (!pendValid) begin
                            // Leftmost six bits go out first
                            pendChar <= wordAssemblyReg[23:18];
                            pendValid <= 1'b1;
                            wordAssemblyReg <= {wordAssemblyReg[17:0],
                                6'h00};
                            singleCharReg <= wordAssemblyReg[17:12];
                            if (lastChar) begin
                                wordFull <= 1'b0;
                                if (interlace) begin
                                    state <= ST_MEMRD;
                                end else begin
                                    wordIrq <= 1'b1;
                                    state <= ST_WAIT;
                                end
                            end else begin
                                charCount <= charCount - 2'd1;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/ciob_channel_props.sv ***
// Port checker for the character buffer channel
`default_nettype none
module ciob_channel_props #(
    parameter ADDR_W = 14,
    parameter WCNT_W = 14
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ctlStrobe,
    input wire logic [23:0] ctlInstr,
    input wire logic ctlInterlace,
    input wire logic [WCNT_W-1:0] ctlWordCount,
    input wire logic [ADDR_W-1:0] ctlStartAddr,
    input wire logic irqSystemEnable,
    input wire logic readyTestSkip,
    input wire logic errorTestSkip,
    input wire logic [5:0] panelUnit,
    input wire logic errorFlag,
    input wire logic wordFull,
    input wire logic wordIrq,
    input wire logic doneIrq,
    input wire logic doneProgramIrq,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic devStart,
    input wire logic devOutValid,
    input wire logic [5:0] devCharOut,
    input wire logic devParityOut
);
    // ==========================================
    // Expected interlace address and words left
    logic [ADDR_W-1:0] expAddr;
    logic [WCNT_W-1:0] left;
    logic ilv;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            expAddr <= '0;
            left <= '0;
            ilv <= 1'b0;
        end else if (ctlStrobe && readyTestSkip) begin
            expAddr <= ctlStartAddr;
            left <= ctlWordCount;
            ilv <= ctlInterlace;
        end else if (memWrite || memRead) begin
            expAddr <= expAddr + 1'b1;
            left <= left - 1'b1;
        end
    end
    // ==========================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_start_unit_load: assert property (ctlStrobe && readyTestSkip &&
        ctlInstr[5:0] != 6'h00 |=> panelUnit == $past(ctlInstr[5:0])
        && devStart) else $error("unit not loaded or device not started");
    a_start_flags_clear: assert property (ctlStrobe && readyTestSkip
        |=> !wordFull && !errorFlag) else $error("flags not cleared");
    a_busy_refuses: assert property (ctlStrobe && !readyTestSkip
        |=> !devStart) else $error("start while connected");
    a_ready_skip_idle: assert property (readyTestSkip ==
        (panelUnit == 6'h00)) else $error("ready skip wrong");
    a_error_skip_flag: assert property (errorTestSkip == errorFlag)
        else $error("error skip wrong");
    a_out_parity_odd: assert property (devOutValid |->
        ^{devParityOut, devCharOut}) else $error("bad output parity");
    a_done_disconnects: assert property (doneIrq |->
        ##[0:1] readyTestSkip) else $error("still connected after end");
    a_word_irq_pulse: assert property (wordIrq |=> !wordIrq)
        else $error("word irq too long");
    a_out_first_irq: assert property (ctlStrobe && readyTestSkip &&
        ctlInstr[5] && !ctlInterlace |=> wordIrq)
        else $error("no word irq on output start");
    a_prog_irq_gate: assert property (doneProgramIrq |->
        doneIrq && irqSystemEnable) else $error("program irq ungated");
    a_interlace_addr: assert property ((memWrite || memRead) |->
        memAddr == expAddr) else $error("interlace address wrong");
    a_word_limit: assert property ((memWrite || memRead) |->
        ilv && left != '0) else $error("too many interlace words");
endmodule
bind ciob_channel ciob_channel_props #(.ADDR_W(ADDR_W), .WCNT_W(WCNT_W))
    chk_u (.clk, .rstn, .ctlStrobe, .ctlInstr, .ctlInterlace, .ctlWordCount,
    .ctlStartAddr, .irqSystemEnable, .readyTestSkip, .errorTestSkip,
    .panelUnit, .errorFlag, .wordFull, .wordIrq, .doneIrq, .doneProgramIrq,
    .memWrite, .memRead, .memAddr, .devStart, .devOutValid, .devCharOut,
    .devParityOut);
`default_nettype wire

// *** bench/ciob_periph_model.sv ***
// Peripheral and memory model on the far side of the channel
`default_nettype none
module ciob_periph_model (
    input wire logic clk,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic [13:0] memAddr,
    input wire logic [23:0] memWriteData,
    output logic memReadValid,
    output logic [23:0] memReadData,
    output logic devCharValid,
    output logic [5:0] devCharIn,
    output logic devParityIn,
    output logic devEndRecord,
    input wire logic devOutValid,
    input wire logic [5:0] devCharOut,
    output logic devOutReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem [0:63];
    logic [5:0] got [$];
    logic [5:0] rdAddr;
    logic readPend, rdy1, rdy2;
    int hold;
    initial begin
        {memReadValid, devCharValid, devParityIn, devEndRecord} = 4'h0;
        {memReadData, devCharIn, readPend, rdAddr, hold} = 0;
        {devOutReady, rdy1, rdy2} = 3'h0;
    end
    // Data settles two cycles before valid so the synchroniser sees it
    task sendChar(input logic [5:0] c, input logic bad);
        @(negedge clk);
        devCharIn = c;
        devParityIn = (~^c) ^ bad;
        repeat (2) @(negedge clk);
        devCharValid = 1'b1;
        repeat (4) @(negedge clk);
        devCharValid = 1'b0;
        devCharIn = ~c;
        repeat (4) @(negedge clk);
    endtask
    task setEor(input logic b);
        @(negedge clk);
        devEndRecord = b;
    endtask
    // Transfers are counted against ready as the channel sees it, synced
    always @(posedge clk) begin
        rdy1 <= devOutReady;
        rdy2 <= rdy1;
        if (devOutValid && rdy2)
            got.push_back(devCharOut);
        if (memWrite)
            mem[memAddr[5:0]] <= memWriteData;
        readPend <= memRead;
        rdAddr <= memAddr[5:0];
    end
    always @(negedge clk) begin
        memReadValid <= readPend;
        memReadData <= readPend ? mem[rdAddr] : ~memReadData;
        hold <= (hold == 0) ? $urandom_range(1, 8) : hold - 1;
        if (hold == 0)
            devOutReady <= ~devOutReady;
    end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench of the character buffer channel
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, ctlStrobe, ctlInterlace, toMemStrobe, fromMemStrobe;
    logic terminateStrobe, irqSystemEnable, readyTestSkip, errorTestSkip;
    logic [23:0] ctlInstr, fromMemWord, cpuWord, memWriteData, memReadData;
    logic [13:0] ctlWordCount, ctlStartAddr, memAddr;
    logic errorFlag, wordFull, wordIrq, doneIrq, doneProgramIrq, devStart;
    logic memWrite, memRead, memReadValid, devCharValid, devCharReady;
    logic [5:0] panelUnit, devUnit, devCharIn, devCharOut, ch [0:3];
    logic devParityIn, devEndRecord, devOutValid, devOutReady, devParityOut;
    logic seen [0:2];
    logic gotProg;
    int fails, checks_done, cyc;
    ciob_channel dut_u (.clk, .rstn, .ctlStrobe, .ctlInstr, .ctlInterlace,
        .ctlWordCount, .ctlStartAddr, .toMemStrobe, .fromMemStrobe,
        .fromMemWord, .terminateStrobe, .irqSystemEnable, .cpuWord,
        .readyTestSkip, .errorTestSkip, .panelUnit, .errorFlag, .wordFull,
        .wordIrq, .doneIrq, .doneProgramIrq, .memWrite, .memRead, .memAddr,
        .memWriteData, .memReadValid, .memReadData, .devStart, .devUnit,
        .devCharValid, .devCharReady, .devCharIn, .devParityIn,
        .devEndRecord, .devOutValid, .devOutReady, .devCharOut,
        .devParityOut);
    ciob_periph_model p (.clk, .memWrite, .memRead, .memAddr, .memWriteData,
        .memReadValid, .memReadData, .devCharValid, .devCharIn, .devParityIn,
        .devEndRecord, .devOutValid, .devCharOut, .devOutReady);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================
    // Event monitor and hang guard
    always @(posedge clk) begin
        cyc++;
        if (wordIrq) seen[0] = 1'b1;
        if (doneIrq) seen[1] = 1'b1;
        if (memWrite) seen[2] = 1'b1;
        if (doneProgramIrq) gotProg = 1'b1;
        if (cyc == 80000) begin
            fails++;
            results();
        end
    end
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task waitEv(input int w);
        for (int n = 0; n < 3000 && seen[w] !== 1'b1; n++)
            @(negedge clk);
        chk("event", 1, seen[w]);
        seen[w] = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    function automatic logic [23:0] pack(input int k, input int n);
        logic [23:0] w;
        w = 24'h000000;
        for (int i = 0; i < k; i++)
            w = {w[17:0], (i < n) ? ch[i] : 6'h00};
        return w;
    endfunction
    // ==========================================
    // Control instruction with random unit, checked on the next edge
    task start(input logic dir, input int k, input logic il, input int wc,
        input int a);
        @(negedge clk);
        ctlInstr = $urandom;
        ctlInstr[8:7] = 2'(k - 1);
        ctlInstr[5] = dir;
        ctlInstr[0] = ctlInstr[0] | ~|ctlInstr[4:1];
        ctlInterlace = il;
        ctlWordCount = 14'(wc);
        ctlStartAddr = 14'(a);
        irqSystemEnable = $urandom;
        seen = '{1'b0, 1'b0, 1'b0};
        gotProg = 1'b0;
        pulse(ctlStrobe);
        chk("unit", ctlInstr[5:0], panelUnit);
        chk("dev unit", ctlInstr[5:0], devUnit);
        chk("full", 0, wordFull);
        chk("error", 0, errorFlag);
        ctlInstr[4:0] = ~ctlInstr[4:0];
        pulse(ctlStrobe);
        chk("refused", {ctlInstr[5], ~ctlInstr[4:0]}, panelUnit);
    endtask
    task inputTest(input logic il);
        int k, r, a;
        logic bad;
        k = $urandom_range(2, 4);
        a = $urandom_range(0, 60);
        bad = $urandom;
        start(1'b0, k, il, 2, a);
        for (int wd = 0; wd < 2; wd++) begin
            for (int i = 0; i < k; i++) begin
                ch[i] = $urandom;
                p.sendChar(ch[i], bad && wd == 1 && i == 0);
            end
            waitEv(il ? 2 : 0);
            if (il)
                chk("mem word", pack(k, k), p.mem[a + wd]);
            else
                chk("cpu word", pack(k, k), cpuWord);
            if (!il)
                pulse(toMemStrobe);
        end
        chk("error skip", bad, errorTestSkip);
        chk("stays on", 0, readyTestSkip);
        r = $urandom_range(1, k - 1);
        for (int i = 0; i < r; i++) begin
            ch[i] = $urandom;
            p.sendChar(ch[i], 1'b0);
        end
        p.setEor(1'b1);
        waitEv(1);
        chk("padded word", pack(k, r), cpuWord);
        chk("prog irq", irqSystemEnable, gotProg);
        chk("ready", 1, readyTestSkip);
        p.setEor(1'b0);
    endtask
    task outputTest(input logic il);
        int k, a;
        logic [23:0] w [0:2];
        k = $urandom_range(1, 4);
        a = $urandom_range(0, 60);
        p.got.delete();
        for (int j = 0; j < 3; j++) begin
            w[j] = $urandom;
            p.mem[a + j] = w[j];
        end
        start(1'b1, k, il, 3, a);
        for (int j = 0; j < 3 && !il; j++) begin
            waitEv(0);
            fromMemWord = w[j];
            pulse(fromMemStrobe);
            if (j == 2)
                pulse(terminateStrobe);
        end
        waitEv(1);
        for (int n = 0; n < 500 && p.got.size() < 3 * k; n++)
            @(negedge clk);
        chk("char count", 3 * k, p.got.size());
        for (int i = 0; i < 3 * k && i < p.got.size(); i++)
            chk("char", w[i / k][23 - 6 * (i % k) -: 6], p.got[i]);
        chk("ready", 1, readyTestSkip);
    endtask
    task results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {rstn, ctlStrobe, ctlInterlace, toMemStrobe, fromMemStrobe} = 5'h00;
        {terminateStrobe, irqSystemEnable, ctlInstr, fromMemWord} = 0;
        {ctlWordCount, ctlStartAddr, fails, checks_done, cyc} = 0;
        seen = '{1'b0, 1'b0, 1'b0};
        gotProg = 1'b0;
        void'($urandom(73644));
        repeat (20) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        chk("ready after reset", 1, readyTestSkip);
        for (int t = 0; t < 6; t++) begin
            inputTest(t % 2);
            outputTest(t % 2);
            $display("test %0d done, mismatches %0d", t, fails);
        end
        results();
    end
endmodule
`default_nettype wire
